// ---- rtl/cnm_mixer.sv ----
// Purpose: Complex mixer: oscillator full mixer plus coarse fs/8, fs/4, fs/2 mixer.
// Assumes: Every clock is a converter sample clock; inputs synchronous to clock_in.
// Notes:   Output follows the input by two clock edges; output saturates.
`timescale 1ns/10ps
module cnm_mixer #(
	parameter int LUT_BITS = 10
) (
	// Clock and reset
	input  wire logic                              clock_in,
	input  wire logic                              rstn_in,
	// Register port
	input  wire cnm_pkg::cnm_bus_t                 bus_in,
	output logic [31:0]                            rdata_out,
	// Synchronisation events
	input  wire logic [cnm_pkg::SYNC_W-1:0]        sync_events_in,
	// Sample streams
	input  wire cnm_pkg::cnm_sample_t              sample_in,
	output cnm_pkg::cnm_sample_t                   sample_out
);

	generate
		if (LUT_BITS < 3 || LUT_BITS > 16) begin : g_bad
			$error("cnm_mixer: LUT_BITS must lie in 3..16");
		end
		// Widths that the fixed-point datapath and the field packing are written for
		if (cnm_pkg::DATA_W != 16 || cnm_pkg::POFF_W != 16) begin : g_bad_data
			$error("cnm_mixer: sample and phase words must be 16 bits");
		end
		if (cnm_pkg::FREQ_W != 32) begin : g_bad_freq
			$error("cnm_mixer: frequency word must be 32 bits");
		end
		if (cnm_pkg::SYNC_W != 4 || cnm_pkg::CMIX_W != 4) begin : g_bad_sel
			$error("cnm_mixer: select fields must be 4 bits");
		end
		if (cnm_pkg::LATENCY != 2) begin : g_bad_lat
			$error("cnm_mixer: the pipeline has exactly two register stages");
		end
	endgenerate

	cnm_pkg::cnm_state_t state;
	cnm_pkg::cnm_state_t next_state;

	// Decode of the coarse select and full-mix enable into datapath steps
	function automatic cnm_pkg::cnm_mode_t decode_mode(
		input logic                       full_complex_mix,
		input logic [cnm_pkg::CMIX_W-1:0] cmix
	);
		cnm_pkg::cnm_mode_t m;
		m = '0;
		case (cmix)
			cnm_pkg::CMIX_NONE: ;                                              // R11
			cnm_pkg::CMIX_NEG4: m.neg4 = 1'b1;                                 // R16
			cnm_pkg::CMIX_HALF: m.half = 1'b1;                                 // R16
			cnm_pkg::CMIX_POS4: m.pos4 = 1'b1;                                 // R16
			cnm_pkg::CMIX_POS8: m.fs8  = 1'b1;                                 // R17
			cnm_pkg::CMIX_NEG38: begin
				m.fs8  = 1'b1;                                                 // R17
				m.half = 1'b1;
			end
			cnm_pkg::CMIX_POS38: begin
				m.fs8  = 1'b1;                                                 // R17
				m.pos4 = 1'b1;
			end
			cnm_pkg::CMIX_NEG8: begin
				m.fs8  = 1'b1;                                                 // R17
				m.pos4 = 1'b1;
				m.half = 1'b1;
			end
			default: m = '0;                                                   // R18
		endcase
		m.mult = full_complex_mix | m.fs8;                                                 // R1
		return m;
	endfunction : decode_mode

	// Negation that keeps the most negative code in range
	function automatic logic signed [cnm_pkg::DATA_W-1:0] neg_sat(
		input logic signed [cnm_pkg::DATA_W-1:0] x
	);
		if (x == 16'sh8000) begin
			return 16'sh7FFF;
		end
		return -x;
	endfunction : neg_sat

	// Clip a wide multiplier result to the sample width
	function automatic logic signed [cnm_pkg::DATA_W-1:0] sat16(
		input logic signed [32:0] v
	);
		if (v > 33'sh000007FFF) begin
			return 16'sh7FFF;                                                  // R19
		end
		if (v < -33'sh000008000) begin
			return 16'sh8000;                                                  // R19
		end
		return v[15:0];
	endfunction : sat16

	// Rotation by the oscillator or fs/8 terms with gain scaling
	function automatic cnm_pkg::cnm_sample_t rotate(
		input cnm_pkg::cnm_sample_t     s,
		input logic signed [15:0]       c,
		input logic signed [15:0]       sn,
		input logic                     gain
	);
		cnm_pkg::cnm_sample_t r;
		logic signed [31:0] p_ic;
		logic signed [31:0] p_qs;
		logic signed [31:0] p_is;
		logic signed [31:0] p_qc;
		logic signed [32:0] sum_i;
		logic signed [32:0] sum_q;
		r     = s;
		// One spare bit on the sums keeps I*c - Q*s from wrapping before the clip
		p_ic  = s.i * c;
		p_qs  = s.q * sn;
		p_is  = s.i * sn;
		p_qc  = s.q * c;
		sum_i = 33'(p_ic) - 33'(p_qs);                                         // R7
		sum_q = 33'(p_is) + 33'(p_qc);                                         // R7
		if (gain) begin
			sum_i = sum_i >>> cnm_pkg::Q_SHIFT_UNIT;                           // R9
			sum_q = sum_q >>> cnm_pkg::Q_SHIFT_UNIT;
		end else begin
			sum_i = sum_i >>> cnm_pkg::Q_SHIFT_HALF;                           // R9
			sum_q = sum_q >>> cnm_pkg::Q_SHIFT_HALF;
		end
		r.i = sat16(sum_i);
		r.q = sat16(sum_q);
		return r;
	endfunction : rotate

	// Negate-and-swap sequences for the quarter and half rate modes
	function automatic cnm_pkg::cnm_sample_t swap_seq(
		input cnm_pkg::cnm_sample_t s,
		input cnm_pkg::cnm_mode_t   m,
		input logic [1:0]           k
	);
		cnm_pkg::cnm_sample_t r;
		r = s;
		if (m.pos4) begin
			case (k)
				2'h1: begin
					r.i = neg_sat(s.q);                                        // R13
					r.q = s.i;
				end
				2'h2: begin
					r.i = neg_sat(s.i);                                        // R13
					r.q = neg_sat(s.q);
				end
				2'h3: begin
					r.i = s.q;                                                 // R13
					r.q = neg_sat(s.i);
				end
				default: r = s;
			endcase
		end else if (m.neg4) begin
			case (k)
				2'h1: begin
					r.i = s.q;                                                 // R14
					r.q = neg_sat(s.i);
				end
				2'h2: begin
					r.i = neg_sat(s.i);                                        // R14
					r.q = neg_sat(s.q);
				end
				2'h3: begin
					r.i = neg_sat(s.q);                                        // R14
					r.q = s.i;
				end
				default: r = s;
			endcase
		end
		// Half-rate negation comes last so it stacks on a quarter-rate swap
		if (m.half && k[0]) begin
			r.i = neg_sat(r.i);                                                // R12
			r.q = neg_sat(r.q);
		end
		return r;
	endfunction : swap_seq

	logic signed [15:0] sin_term;
	logic signed [15:0] cos_term;
	logic [15:0]        mult_phase;

	// Oscillator or fs/8 phase feeds the shared table; parked at zero while bypassed
	always_comb begin
		if (state.st1.mode.mult) begin
			mult_phase = state.st1.phase;
		end else begin
			mult_phase = 16'h0000;
		end
	end

	cnm_sincos #(
		.LUT_BITS (LUT_BITS)
	) u_sincos (
		.phase_in (mult_phase),
		.sin_out  (sin_term),
		.cos_out  (cos_term)
	);

	logic                         sync_hit;
	logic [cnm_pkg::POFF_W-1:0]   nco_phase;
	logic [cnm_pkg::POFF_W-1:0]   fs8_phase;
	cnm_pkg::cnm_mode_t           cur_mode;
	cnm_pkg::cnm_sample_t         mixed;

	always_comb begin
		next_state = state;
		next_state.rdata = 32'h00000000;

		// Register writes
		if (bus_in.wr) begin
			case (bus_in.addr)
				cnm_pkg::OFS_FREQ: next_state.freq = bus_in.wdata;             // R2
				cnm_pkg::OFS_POFF: next_state.poff = bus_in.wdata[15:0];       // R2
				cnm_pkg::OFS_CTRL: begin
					next_state.full_complex_mix     = bus_in.wdata[cnm_pkg::CTRL_FULL_COMPLEX_MIX_BIT];
					next_state.gain     = bus_in.wdata[cnm_pkg::CTRL_GAIN_BIT];
					next_state.cmix     = bus_in.wdata[cnm_pkg::CTRL_CMIX_LSB +: cnm_pkg::CMIX_W];
					next_state.sync_sel = bus_in.wdata[cnm_pkg::CTRL_SYNC_LSB +: cnm_pkg::SYNC_W]; // R4
				end
				default: ;
			endcase
		end

		// Register reads, answered on the next cycle
		if (bus_in.rd) begin
			case (bus_in.addr)
				cnm_pkg::OFS_FREQ: next_state.rdata = state.freq;
				cnm_pkg::OFS_POFF: next_state.rdata = {16'h0000, state.poff};
				cnm_pkg::OFS_CTRL: begin
					next_state.rdata[cnm_pkg::CTRL_FULL_COMPLEX_MIX_BIT] = state.full_complex_mix;
					next_state.rdata[cnm_pkg::CTRL_GAIN_BIT] = state.gain;
					next_state.rdata[cnm_pkg::CTRL_CMIX_LSB +: cnm_pkg::CMIX_W] = state.cmix;
					next_state.rdata[cnm_pkg::CTRL_SYNC_LSB +: cnm_pkg::SYNC_W] = state.sync_sel;
				end
				cnm_pkg::OFS_ACC:    next_state.rdata = state.acc;
				cnm_pkg::OFS_STATUS: next_state.rdata = {13'h0000, state.seq, state.sync_count};
				default:             next_state.rdata = 32'h00000000;
			endcase
		end

		// Oscillator accumulator and coarse sample sequence
		// A selected sync event wins over the increment and restarts the coarse sequence
		sync_hit = |(sync_events_in & state.sync_sel);                         // R4
		if (sync_hit) begin
			next_state.acc        = 32'h00000000;                              // R3
			next_state.seq        = 3'h0;
			next_state.sync_count = state.sync_count + 16'h0001;
		end else begin
			next_state.acc = state.acc + state.freq;                           // R5 R6
			if (sample_in.valid) begin
				next_state.seq = state.seq + 3'h1;
			end
		end

		// Stage one: capture sample, phase and mode
		cur_mode  = decode_mode(state.full_complex_mix, state.cmix);                       // R16
		nco_phase = state.acc[31:16] + state.poff;                             // R8
		fs8_phase = {state.seq, 13'h0000};                                     // R15
		next_state.st1.smp  = sample_in;
		next_state.st1.mode = cur_mode;
		next_state.st1.gain = state.gain;
		next_state.st1.seq  = state.seq;
		if (state.full_complex_mix) begin
			next_state.st1.phase = nco_phase;                                  // R7
		end else begin
			next_state.st1.phase = fs8_phase;                                  // R15
		end

		// Stage two: multiplier, then negate-and-swap
		// Swaps follow the multiplier so fs/8 combines with the fs/4 and fs/2 steps
		mixed = state.st1.smp;                                                 // R11
		if (state.st1.mode.mult) begin
			mixed = rotate(state.st1.smp, cos_term, sin_term, state.st1.gain); // R7 R15
		end
		mixed = swap_seq(mixed, state.st1.mode, state.st1.seq[1:0]);           // R10
		mixed.valid = state.st1.smp.valid;
		next_state.out = mixed;
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			// Control fields take their reset values; the pipeline starts empty
			state          <= '0;
			state.freq     <= cnm_pkg::RST_FREQ;
			state.poff     <= cnm_pkg::RST_POFF;
			state.full_complex_mix     <= cnm_pkg::RST_FULL_COMPLEX_MIX;
			state.gain     <= cnm_pkg::RST_GAIN;
			state.cmix     <= cnm_pkg::RST_CMIX;
			state.sync_sel <= cnm_pkg::RST_SYNC;
		end else begin
			state <= next_state;
		end
	end

	assign rdata_out  = state.rdata;
	assign sample_out = state.out;

endmodule : cnm_mixer

// ---- include/cnm_pkg.sv ----
// Purpose: Shared constants and carriers of the complex mixer block.
// Assumes: One 25 MHz sample clock; one I/Q sample pair per valid cycle.
// Notes:   Register offsets are byte addresses on a plain 32-bit register port.
//
// Behaviour
// R1 - Mixing path holds an oscillator-driven full mixer plus a coarse fixed-step mixer.
// R2 - Oscillator keeps a 32-bit frequency word and a 16-bit phase offset.
// R3 - A selected sync event clears the phase accumulator to zero.
// R4 - A 4-bit source select picks which sync events clear the accumulator.
// R5 - The frequency word is added to the accumulator every clock, modulo 2^32.
// R6 - Output frequency is frequency word times clock rate over 2^32.
// R7 - Full mix rotates I/Q by oscillator phase, scaled by 2^(gain-1).
// R8 - Phase offset adds 2*pi*offset/2^16 to the oscillator phase.
// R9 - Gain select 0 halves the multiplier output; 1 keeps unit scale.
// R10 - fs/2 and +/-fs/4 modes bypass the multiplier; gain has no effect.
// R11 - With no coarse mixing, samples pass unchanged.
// R12 - fs/2 mode negates I and Q on the second and fourth sample.
// R13 - +fs/4 follows I: +I,-Q,-I,+Q and Q: +Q,+I,-Q,-I.
// R14 - -fs/4 follows I: +I,+Q,-I,-Q and Q: +Q,-I,-Q,+I.
// R15 - fs/8 mode uses the multiplier with fixed fs/8 terms and gain, combinable.
// R16 - Coarse select bits: 3 fs/8, 2 +fs/4, 1 fs/2, 0 -fs/4; zero is none.
// R17 - Codes 1000 +fs/8, 1010 -3fs/8, 1100 +3fs/8, 1110 -fs/8.
// R18 - Software programs only listed coarse codes; others act as no mixing.
// R19 - Unit gain with full-scale inputs may clip; output saturates.
package cnm_pkg;

	// Widths
	localparam int DATA_W  = 16;
	localparam int FREQ_W  = 32;
	localparam int POFF_W  = 16;
	localparam int ADDR_W  = 8;
	localparam int SYNC_W  = 4;
	localparam int CMIX_W  = 4;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_FREQ   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_POFF   = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_ACC    = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

	// Control register field positions
	localparam int CTRL_FULL_COMPLEX_MIX_BIT = 0;
	localparam int CTRL_GAIN_BIT = 1;
	localparam int CTRL_CMIX_LSB = 4;
	localparam int CTRL_SYNC_LSB = 8;

	// Values after reset
	localparam logic [FREQ_W-1:0] RST_FREQ = 32'h00000000;
	localparam logic [POFF_W-1:0] RST_POFF = 16'h0000;
	localparam logic              RST_FULL_COMPLEX_MIX = 1'b0;
	localparam logic              RST_GAIN = 1'b1;
	localparam logic [CMIX_W-1:0] RST_CMIX = 4'h0;
	localparam logic [SYNC_W-1:0] RST_SYNC = 4'h0;

	// Coarse select codes
	localparam logic [CMIX_W-1:0] CMIX_NONE   = 4'h0;
	localparam logic [CMIX_W-1:0] CMIX_NEG4   = 4'h1;
	localparam logic [CMIX_W-1:0] CMIX_HALF   = 4'h2;
	localparam logic [CMIX_W-1:0] CMIX_POS4   = 4'h4;
	localparam logic [CMIX_W-1:0] CMIX_POS8   = 4'h8;
	localparam logic [CMIX_W-1:0] CMIX_NEG38  = 4'hA;
	localparam logic [CMIX_W-1:0] CMIX_POS38  = 4'hC;
	localparam logic [CMIX_W-1:0] CMIX_NEG8   = 4'hE;

	// Multiplier scaling: sine table is Q15, half gain shifts one more
	localparam int Q_SHIFT_UNIT = 15;
	localparam int Q_SHIFT_HALF = 16;

	// Phase step of one fs/8 sample in a 16-bit phase word
	localparam int FS8_STEP_LSB = 13;

	// Pipeline depth from input sample to output sample, in clock edges
	localparam int LATENCY = 2;

	typedef struct packed {
		logic               wr;
		logic               rd;
		logic [ADDR_W-1:0]  addr;
		logic [31:0]        wdata;
	} cnm_bus_t;

	typedef struct packed {
		logic                     valid;
		logic signed [DATA_W-1:0] i;
		logic signed [DATA_W-1:0] q;
	} cnm_sample_t;

	typedef struct packed {
		logic mult;
		logic fs8;
		logic pos4;
		logic half;
		logic neg4;
	} cnm_mode_t;

	typedef struct packed {
		cnm_sample_t        smp;
		logic [POFF_W-1:0]  phase;
		logic [2:0]         seq;
		cnm_mode_t          mode;
		logic               gain;
	} cnm_stage_t;

	typedef struct packed {
		logic [FREQ_W-1:0]  freq;
		logic [POFF_W-1:0]  poff;
		logic               full_complex_mix;
		logic               gain;
		logic [CMIX_W-1:0]  cmix;
		logic [SYNC_W-1:0]  sync_sel;
		logic [FREQ_W-1:0]  acc;
		logic [2:0]         seq;
		logic [15:0]        sync_count;
		cnm_stage_t         st1;
		cnm_sample_t        out;
		logic [31:0]        rdata;
	} cnm_state_t;

endpackage : cnm_pkg

// ---- rtl/cnm_sincos.sv ----
// Purpose: Sine and cosine of a 16-bit phase from a quarter-wave table.
// Assumes: Phase 0..65535 spans one full turn; outputs are Q15.
// Notes:   Combinational; the table is filled at elaboration.
`timescale 1ns/10ps
module cnm_sincos #(
	parameter int LUT_BITS = 10
) (
	// Phase
	input  wire logic [15:0]        phase_in,
	// Terms
	output logic signed [15:0]      sin_out,
	output logic signed [15:0]      cos_out
);
	localparam int  IDX_W = LUT_BITS - 2;
	localparam int  N     = 1 << IDX_W;
	localparam real PI    = 3.14159265358979;

	generate
		if (LUT_BITS < 3 || LUT_BITS > 16) begin : g_bad
			$error("cnm_sincos: LUT_BITS must lie in 3..16");
		end
	endgenerate

	logic signed [15:0] quarter_table [0:N];

	generate
		for (genvar k = 0; k <= N; k++) begin : g_tab
			assign quarter_table[k] = 16'(int'(32767.0 * $sin(PI * k / (2.0 * N))));
		end
	endgenerate

	logic [1:0]       quadrant;
	logic [IDX_W:0]   idx;
	logic [IDX_W:0]   ridx;
	logic signed [15:0] t_fwd;
	logic signed [15:0] t_rev;

	always_comb begin
		quadrant = phase_in[15:14];
		idx      = {1'b0, phase_in[13 -: IDX_W]};
		ridx     = (IDX_W+1)'(N) - idx;
		t_fwd    = quarter_table[idx];
		t_rev    = quarter_table[ridx];
		case (quadrant)
			2'h0: begin
				sin_out = t_fwd;
				cos_out = t_rev;
			end
			2'h1: begin
				sin_out = t_rev;
				cos_out = -t_fwd;
			end
			2'h2: begin
				sin_out = -t_fwd;
				cos_out = -t_rev;
			end
			default: begin
				sin_out = -t_rev;
				cos_out = t_fwd;
			end
		endcase
	end

endmodule : cnm_sincos

// ---- tb/cnm_stream_source.sv ----
// Purpose: Upstream sample source feeding paired I/Q samples to the mixer.
// Assumes: Samples are queued by the bench and leave in order.
// Notes:   Idle cycles carry inverted data so stale values never match.
`timescale 1ns/10ps
module cnm_stream_source (
	// Clock and reset
	input  wire logic           clock_in,
	input  wire logic           rstn_in,
	// Pacing
	input  wire logic           slow_in,
	// Stream
	output cnm_pkg::cnm_sample_t sample_out
);
	cnm_pkg::cnm_sample_t fifo[$];
	logic                 gap;

	task automatic send(input logic signed [15:0] i, input logic signed [15:0] q);
		fifo.push_back({1'b1, i, q});
	endtask : send

	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sample_out <= '0;
			gap        <= 1'b0;
		end else if (fifo.size() != 0 && !gap) begin
			sample_out <= fifo.pop_front();
			gap        <= slow_in;
		end else begin
			sample_out <= {1'b0, ~sample_out.i, ~sample_out.q};
			gap        <= 1'b0;
		end
	end
endmodule : cnm_stream_source

// ---- tb/cnm_mixer_checker.sv ----
// Purpose: Port assertions of the complex mixer.
// Assumes: Shadows of control and coarse sequence follow writes and syncs.
// Notes:   Coarse checks skip the most negative sample value.
`timescale 1ns/10ps
module cnm_mixer_checker (
	// Clock and reset
	input  wire logic                         clock_in,
	input  wire logic                         rstn_in,
	// Watched ports
	input  wire cnm_pkg::cnm_bus_t            bus_in,
	input  wire logic [31:0]                  rdata_out,
	input  wire logic [cnm_pkg::SYNC_W-1:0]   sync_events_in,
	input  wire cnm_pkg::cnm_sample_t         sample_in,
	input  wire cnm_pkg::cnm_sample_t         sample_out
);
	logic [11:0] ctrl;
	logic [2:0]  seq;
	logic        hit;
	logic        ok;
	assign hit = (sync_events_in & ctrl[11:8]) != 4'h0;
	assign ok  = sample_in.valid && !ctrl[0] && sample_in.i != 16'h8000 && sample_in.q != 16'h8000;
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl <= 12'h002;
			seq  <= 3'h0;
		end else begin
			if (bus_in.wr && bus_in.addr == cnm_pkg::OFS_CTRL) begin
				ctrl <= bus_in.wdata[11:0] & 12'hFF3;
			end
			seq <= hit ? 3'h0 : seq + 3'(sample_in.valid);
		end
	end
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	rd_idle_a: assert property (!bus_in.rd |=> rdata_out == 32'h0)
		else $error("read data not idle");
	rd_unmapped_a: assert property (bus_in.rd && bus_in.addr > cnm_pkg::OFS_STATUS |=> rdata_out == 32'h0)
		else $error("unmapped read not zero");
	ctrl_read_a: assert property (bus_in.rd && bus_in.addr == cnm_pkg::OFS_CTRL |=> (rdata_out & 32'hFF3) == {20'h0, ctrl})
		else $error("control readback wrong");
	valid_lat_a: assert property (sample_in.valid |-> ##2 sample_out.valid)
		else $error("sample lost");
	gap_lat_a: assert property (!sample_in.valid |-> ##2 !sample_out.valid)
		else $error("spurious sample");
	sync_clear_a: assert property (hit ##1 (hit && bus_in.rd && bus_in.addr == cnm_pkg::OFS_ACC) |=> rdata_out == 32'h0)
		else $error("accumulator not cleared");
	pass_thru_a: assert property (ok && ctrl[7:4] == 4'h0 |-> ##2 sample_out == $past(sample_in, 2))
		else $error("bypass altered sample");
	half_neg_a: assert property (ok && ctrl[7:4] == cnm_pkg::CMIX_HALF && seq[0] |-> ##2
		sample_out.i == -$past(sample_in.i, 2) && sample_out.q == -$past(sample_in.q, 2)) else $error("fs2 sign wrong");
	pos_quarter_a: assert property (ok && ctrl[7:4] == cnm_pkg::CMIX_POS4 && seq[1:0] == 2'h1 |-> ##2
		sample_out.i == -$past(sample_in.q, 2) && sample_out.q == $past(sample_in.i, 2)) else $error("pos fs4 wrong");
	neg_quarter_a: assert property (ok && ctrl[7:4] == cnm_pkg::CMIX_NEG4 && seq[1:0] == 2'h1 |-> ##2
		sample_out.i == $past(sample_in.q, 2) && sample_out.q == -$past(sample_in.i, 2)) else $error("neg fs4 wrong");
endmodule : cnm_mixer_checker

bind cnm_mixer cnm_mixer_checker i_checker (.clock_in(clock_in), .rstn_in(rstn_in), .bus_in(bus_in),
	.rdata_out(rdata_out), .sync_events_in(sync_events_in), .sample_in(sample_in), .sample_out(sample_out));

// ---- tb/cnm_mixer_bench.sv ----
// Purpose: Self-checking bench of the complex mixer.
// Assumes: Oscillator phase held at zero during full-mix runs.
// Notes:   Multiplier results are only predicted at zero phase.
`timescale 1ns/10ps
module cnm_mixer_bench;
	logic                 clock_in;
	logic                 rstn_in;
	logic                 slow;
	logic                 rd_d = 1'b0;
	cnm_pkg::cnm_bus_t    bus;
	logic [31:0]          rdata_out;
	logic [3:0]           sync_ev;
	cnm_pkg::cnm_sample_t smp_in;
	cnm_pkg::cnm_sample_t smp_out;
	int                   err_count;
	int                   num_checks;
	int                   k;
	logic [32:0]          exp_q[$];
	logic [32:0]          rd_q[$];
	logic [31:0]          acc_seen[$];
	logic [32:0]          e_m;
	logic [5:0]           modes[13] = '{6'h01, 6'h08, 6'h10, 6'h04, 6'h0C, 6'h11, 6'h17, 6'h23,
		6'h20, 6'h29, 6'h31, 6'h39, 6'h02};

	cnm_mixer #(.LUT_BITS(10)) i_dut (.clock_in(clock_in), .rstn_in(rstn_in), .bus_in(bus), .rdata_out(rdata_out),
		.sync_events_in(sync_ev), .sample_in(smp_in), .sample_out(smp_out));
	cnm_stream_source i_src (.clock_in(clock_in), .rstn_in(rstn_in), .slow_in(slow), .sample_out(smp_in));

	initial begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict;
		if (err_count == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : give_verdict

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock_in);
		bus <= '0;
		@(posedge clock_in);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic c, input logic [31:0] v);
		rd_q.push_back({c, v});
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clock_in);
		bus <= '0;
		@(posedge clock_in);
	endtask : rd

	function automatic logic signed [15:0] neg(input logic signed [15:0] x);
		return (x == 16'sh8000) ? 16'sh7FFF : -x;
	endfunction : neg

	// Prediction per sample index; zero care bit means no prediction
	function automatic logic [32:0] calc(input logic [5:0] m, input int n, input logic signed [15:0] i,
		input logic signed [15:0] q);
		logic signed [15:0] oi;
		logic signed [15:0] oq;
		logic [3:0]         c;
		logic               f8;
		c  = m[5:2];
		f8 = c[3] && !c[0];
		oi = i;
		oq = q;
		if (m[0] || f8) begin
			if (!m[0] && n % 8 != 0) return 33'h0;
			oi = 16'((32'(i) * 32767) >>> (m[1] ? 15 : 16));
			oq = 16'((32'(q) * 32767) >>> (m[1] ? 15 : 16));
		end
		if (c == cnm_pkg::CMIX_NEG4 || (c[2] && (c == cnm_pkg::CMIX_POS4 || f8))) begin
			case (n % 4)
				1: {oi, oq} = (c[2]) ? {neg(oq), oi} : {oq, neg(oi)};
				2: {oi, oq} = {neg(oi), neg(oq)};
				3: {oi, oq} = (c[2]) ? {oq, neg(oi)} : {neg(oq), oi};
				default: ;
			endcase
		end
		if (c[1] && (c == cnm_pkg::CMIX_HALF || f8) && n % 2 == 1) {oi, oq} = {neg(oi), neg(oq)};
		return {1'b1, oi, oq};
	endfunction : calc

	task automatic stream(input logic [5:0] m, input int n);
		logic signed [15:0] i;
		logic signed [15:0] q;
		wr(cnm_pkg::OFS_CTRL, {24'h0, m[5:2], 2'b00, m[1], m[0]});
		for (int s = 0; s < n; s++) begin
			i = 16'($urandom);
			q = 16'($urandom);
			exp_q.push_back(calc(m, k, i, q));
			k++;
			i_src.send(i, q);
		end
		for (int t = 0; t < 200 && i_src.fifo.size() != 0; t++) @(posedge clock_in);
		repeat (4) @(posedge clock_in);
		if (i_src.fifo.size() != 0) begin
			check("stream drain", 32'h1, 32'h0);
			give_verdict;
		end
	endtask : stream

	always @(posedge clock_in) rd_d <= bus.rd;

	always @(negedge clock_in) begin
		if (smp_out.valid === 1'b1) begin
			if (exp_q.size() == 0) check("sample count", 32'h1, 32'h0);
			else begin
				e_m = exp_q.pop_front();
				if (e_m[32]) check("sample", {smp_out.i, smp_out.q}, e_m[31:0]);
			end
		end
		if (rd_d) begin
			e_m = rd_q.pop_front();
			if (e_m[32]) check("read data", rdata_out, e_m[31:0]);
			else acc_seen.push_back(rdata_out);
		end
	end

	initial begin
		void'($urandom(32'h5385));
		{rstn_in, slow, sync_ev, bus, err_count, num_checks, k} = '0;
		repeat (20) @(posedge clock_in);
		rstn_in <= 1'b1;
		@(posedge clock_in);
		rd(cnm_pkg::OFS_FREQ, 1'b1, cnm_pkg::RST_FREQ);
		rd(cnm_pkg::OFS_CTRL, 1'b1, {20'h0, cnm_pkg::RST_SYNC, cnm_pkg::RST_CMIX, 2'b00, cnm_pkg::RST_GAIN,
			cnm_pkg::RST_FULL_COMPLEX_MIX});
		rd(8'h20, 1'b1, 32'h0);
		wr(cnm_pkg::OFS_FREQ, 32'h9E3779B9);
		wr(cnm_pkg::OFS_POFF, 32'hABCD1234);
		rd(cnm_pkg::OFS_POFF, 1'b1, 32'h00001234);
		wr(cnm_pkg::OFS_CTRL, 32'h00000202);
		sync_ev <= 4'h1;
		rd(cnm_pkg::OFS_ACC, 1'b0, 32'h0);
		rd(cnm_pkg::OFS_ACC, 1'b0, 32'h0);
		@(posedge clock_in);
		check("acc step", acc_seen[1] - acc_seen[0], 32'h3C6EF372);
		sync_ev <= 4'h2;
		@(posedge clock_in);
		rd(cnm_pkg::OFS_ACC, 1'b1, 32'h0);
		wr(cnm_pkg::OFS_FREQ, 32'h0);
		wr(cnm_pkg::OFS_POFF, 32'h0);
		rd(cnm_pkg::OFS_ACC, 1'b1, 32'h0);
		sync_ev <= 4'h0;
		rd(cnm_pkg::OFS_STATUS, 1'b1, 32'h00000009);
		k = 0;
		foreach (modes[n]) begin
			slow <= n[0];
			stream(modes[n], 12);
		end
		check("pending samples", 32'(exp_q.size()), 32'h0);
		give_verdict;
	end
endmodule : cnm_mixer_bench
